// ### sim/mebi_ext_model.sv
module mebi_ext_model
   import mebi_pkg::*;
(
   // Clock.
   input  wire logic              clk_sys_i,
   // Strobes from the device.
   input  wire logic              ale_i,
   input  wire logic              program_fetch_strobe_n_n_i,
   input  wire logic              rd_n_i,
   input  wire logic              wr_n_i,
   input  wire logic              expander_strobe_i,
   // Resolved pins and this model's drive.
   input  wire logic [DATA_W-1:0] bus_i,
   input  wire logic [NIB_W-1:0]  p2_i,
   output logic      [DATA_W-1:0] bus_o,
   output logic      [NIB_W-1:0]  p2_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [PC_W-1:0]   addr;
   logic [DATA_W-1:0] dmem [256];
   logic [NIB_W-1:0]  xport [4];
   logic [NIB_W-1:0]  cmd;
   logic [DATA_W-1:0] bus_last;
   logic [NIB_W-1:0]  p2_last;

   // The external latch takes the address as the strobe falls.
   always @(negedge ale_i) addr = {p2_i, bus_i};

   // Write data is taken at the end of the write strobe, where it must still be valid.
   always @(posedge wr_n_i) dmem[addr[7:0]] = bus_i;

   // First nibble is held while the strobe idles; the data nibble acts while it is low.
   always @(posedge clk_sys_i) begin
      bus_last <= bus_i;
      p2_last <= p2_i;
      if (expander_strobe_i) cmd <= p2_i;
      else case (cmd[3:2])
         EXP_OP_WRITE: xport[cmd[1:0]] <= p2_i;
         EXP_OP_OR: xport[cmd[1:0]] <= xport[cmd[1:0]] | p2_i;
         EXP_OP_AND: xport[cmd[1:0]] <= xport[cmd[1:0]] & p2_i;
         default: ;
      endcase
   end

   // Released lines show an inverted stale value, so a late capture never sees good data.
   assign bus_o = !program_fetch_strobe_n_n_i ? (addr[7:0] ^ {2{addr[11:8]}}) : !rd_n_i ? dmem[addr[7:0]] : ~bus_last;
   assign p2_o = (!expander_strobe_i && cmd[3:2] == EXP_OP_READ) ? xport[cmd[1:0]] : ~p2_last;
endmodule // mebi_ext_model

// ### sim/mebi_top_tb.sv
module mebi_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import mebi_pkg::*;
   logic clk_sys_i, reset_i, fetch_req_i, data_rd_req_i, data_wr_req_i, exp_req_i, clock_output_enable_op_i;
   logic mixed_mode_i, ram_wr_i, ram_rd_i, reset_pin_n_i, external_access_select_i, external_access_select_hv_i;
   logic single_step_run_i, cycle_start_o, op_done_o, instr_valid_o, address_latch_o, program_fetch_strobe_n_o;
   logic read_strobe_n_o, write_strobe_n_o, expander_strobe_o, data_bus_lines_oe_n_o, port2_low_nibble_oe_n_o;
   logic test0_pin_o, test0_pin_oe_n_o;
   logic [PC_W-1:0]   fetch_pc_i;
   logic [DATA_W-1:0] pointer_registers_i, data_wdata_i, instr_o, rd_data_o, ram_wdata_i, ram_rdata_o, rom_data_i;
   logic [DATA_W-1:0] data_bus_lines_i, data_bus_lines_o, bus_m;
   logic [1:0]        exp_code_i;
   logic [2:0]        exp_port_i;
   logic [NIB_W-1:0]  exp_wdata_i, exp_rdata_o, port2_low_nibble_i, port2_low_nibble_o, p2_m;
   logic [RAM_AW-1:0] ram_addr_i;
   logic [ROM_AW-1:0] rom_addr_o;
   logic              fix_on = 1'b0;
   logic [DATA_W-1:0] fix_bus;
   logic [NIB_W-1:0]  fix_p2;
   int                error_cnt = 0;
   int                compares = 0;
   int                program_fetch_strobe_n_cnt = 0;
   int                n;
   // Row: kind (0 fetch, 1 write, 2 read, 3 expander), address or {code,port}, data, expected.
   logic [31:0]       rows [15] = '{32'h0000_0000, 32'h09a5_003c, 32'h107e_d200, 32'h1000_8100, 32'h207e_00d2,
                                    32'h2000_0081, 32'h300d_0a00, 32'h3015_0500, 32'h3005_000f, 32'h301d_0600,
                                    32'h3005_0006, 32'h300f_0300, 32'h3007_0003, 32'h300c_0900, 32'h3004_0009};

   mebi_top dut_u (.*);
   mebi_ext_model mem_u (.clk_sys_i(clk_sys_i), .ale_i(address_latch_o), .program_fetch_strobe_n_n_i(program_fetch_strobe_n_o),
      .rd_n_i(read_strobe_n_o), .wr_n_i(write_strobe_n_o), .expander_strobe_i(expander_strobe_o),
      .bus_i(data_bus_lines_i), .p2_i(port2_low_nibble_i), .bus_o(bus_m), .p2_o(p2_m));

   // Each pin carries whichever side is driving it; the read-out fixture replaces the model when on.
   assign data_bus_lines_i = !data_bus_lines_oe_n_o ? data_bus_lines_o : fix_on ? fix_bus : bus_m;
   assign port2_low_nibble_i = !port2_low_nibble_oe_n_o ? port2_low_nibble_o : fix_on ? fix_p2 : p2_m;
   assign rom_data_i = rom_addr_o[7:0] ^ 8'h33;

   always #4 clk_sys_i = ~clk_sys_i;
   always @(negedge program_fetch_strobe_n_o) program_fetch_strobe_n_cnt++;

   task automatic tick;
      @(posedge clk_sys_i);
      #1;
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         error_cnt++;
      end
   endtask

   task automatic end_sim;
      $display("compares=%0d error_cnt=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // Lets one edge pass so a new request never lands in the step that dropped the last one,
   // then holds the request until its completion pulse.
   task automatic run_op(input logic [31:0] r);
      int i;
      int cs;
      cs = 0;
      tick();
      fetch_req_i = r[31:28] == 4'h0;
      data_wr_req_i = r[31:28] == 4'h1;
      data_rd_req_i = r[31:28] == 4'h2;
      exp_req_i = r[31:28] == 4'h3;
      fetch_pc_i = r[27:16];
      pointer_registers_i = r[23:16];
      data_wdata_i = r[15:8];
      {exp_code_i, exp_port_i} = r[20:16];
      exp_wdata_i = r[11:8];
      for (i = 0; i < 60 && op_done_o !== 1'b1; i++) begin
         tick();
         cs += cycle_start_o;
      end
      if (i == 60) begin
         error_cnt++;
         end_sim();
      end
      check(8'(cs), 8'h01);
      {fetch_req_i, data_wr_req_i, data_rd_req_i, exp_req_i} = 4'h0;
   endtask

   initial begin
      {clk_sys_i, fetch_req_i, data_rd_req_i, data_wr_req_i, exp_req_i, clock_output_enable_op_i} = 6'h00;
      {mixed_mode_i, ram_wr_i, ram_rd_i, external_access_select_hv_i, fetch_pc_i} = 16'h0000;
      {reset_i, reset_pin_n_i, external_access_select_i, single_step_run_i} = 4'hf;
      {pointer_registers_i, data_wdata_i, ram_wdata_i, exp_code_i, exp_port_i, exp_wdata_i} = 33'h0;
      ram_addr_i = 7'h00;
      repeat (4) tick();
      reset_i = 1'b0;
      check({program_fetch_strobe_n_o, read_strobe_n_o, write_strobe_n_o, data_bus_lines_oe_n_o}, 8'h0f);
      $display("reset test done");
      foreach (rows[k]) begin
         run_op(rows[k]);
         if (rows[k][31:28] == 4'h0) check({instr_valid_o, instr_o}, {1'b1, rows[k][7:0]});
         if (rows[k][31:28] == 4'h2) check(rd_data_o, rows[k][7:0]);
         if (rows[k][31:24] == 8'h30 && rows[k][20:19] == EXP_OP_READ) check(exp_rdata_o, rows[k][7:0]);
      end
      $display("table test done");
      // Mixed mode: low address stays inside, the first address beyond the ROM goes out.
      {external_access_select_i, mixed_mode_i} = 2'h1;
      n = program_fetch_strobe_n_cnt;
      run_op(32'h0123_0000);
      check(instr_o, 8'h10);
      check(8'(program_fetch_strobe_n_cnt - n), 8'h00);
      run_op(32'h0800_0000);
      check(instr_o, 8'h88);
      $display("mixed mode test done");
      // Single step: a request while stopped is not served until the input rises.
      single_step_run_i = 1'b0;
      repeat (20) tick();
      fetch_req_i = 1'b1;
      n = 0;
      repeat (45) begin
         tick();
         n += op_done_o;
      end
      check({address_latch_o, 7'(n)}, 8'h80);
      single_step_run_i = 1'b1;
      run_op(32'h0800_0000);
      check(instr_o, 8'h88);
      $display("single step test done");
      // Data RAM refuses writes while the reset pin is low.
      {ram_addr_i, ram_wdata_i, ram_wr_i} = {7'h05, 8'h3c, 1'b1};
      tick();
      {reset_pin_n_i, ram_wdata_i, ram_rd_i} = {1'b0, 8'hc3, 1'b1};
      tick();
      check(ram_rdata_o, 8'h00);
      {reset_pin_n_i, ram_wr_i, ram_rd_i} = 3'h5;
      tick();
      ram_rd_i = 1'b0;
      tick();
      check(ram_rdata_o, 8'h3c);
      $display("standby test done");
      // Clock output: one phase-two pulse per state, five per machine cycle.
      clock_output_enable_op_i = 1'b1;
      tick();
      clock_output_enable_op_i = 1'b0;
      repeat (3) tick();
      n = 0;
      repeat (15) begin
         tick();
         n += test0_pin_o;
      end
      check({test0_pin_oe_n_o, 7'(n)}, 8'h05);
      $display("clock output test done");
      // Read-out: the fixture holds the address while the reset pin rises, then the ROM byte comes out.
      {fix_on, fix_bus, fix_p2} = {1'b1, 8'h5a, 4'h6};
      {external_access_select_hv_i, reset_pin_n_i} = 2'h2;
      repeat (2) tick();
      reset_pin_n_i = 1'b1;
      repeat (5) tick();
      check(data_bus_lines_o, 8'h69);
      check({rom_addr_o[10:8], 4'h0, data_bus_lines_oe_n_o}, 8'h40);
      $display("read-out test done");
      end_sim();
   end
endmodule // mebi_top_tb

// ### src/mebi_phase.sv
module mebi_phase
   import mebi_pkg::*;
#(
   parameter int CLKS = CLKS_PER_STATE
) (
   // Clock and reset.
   input  wire logic     clk_sys_i,
   input  wire logic     reset_i,
   // Control.
   input  wire logic     stall_i,
   // Timing outputs.
   output mebi_state_type state_o,
   output logic          tick_o,
   output logic          ph2_o
);

   localparam int CW = (CLKS > 1) ? $clog2(CLKS) : 1;

   logic [CW-1:0] cnt;

   // The state advances on the last clock of its slot unless stalled.
   assign tick_o = (cnt == CW'(CLKS - 1)) && !stall_i;

   // Clock divider inside one state; it freezes on its last count while stalled.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         cnt <= '0;
      end else if (tick_o) begin
         cnt <= '0;
      end else if (cnt != CW'(CLKS - 1)) begin
         cnt <= cnt + CW'(1);
      end
   end

   // Five states per machine cycle, wrapping after the fifth.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         state_o <= st_addr;
      end else if (tick_o) begin
         case (state_o)
            st_addr:     state_o <= st_hold;
            st_hold:     state_o <= st_strobe_a;
            st_strobe_a: state_o <= st_strobe_b;
            st_strobe_b: state_o <= st_finish;
            default:     state_o <= st_addr;
         endcase
      end
   end

   // Phase-two clock is high in the first clock of each state.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         ph2_o <= 1'b0;
      end else begin
         ph2_o <= tick_o;
      end
   end

endmodule // mebi_phase

// ### src/mebi_pkg.sv
package mebi_pkg;

   // Bus geometry.
   localparam int DATA_W           = 8;
   localparam int NIB_W            = 4;
   localparam int PC_W             = 12;
   localparam int ROM_AW           = 11;
   localparam int RAM_AW           = 7;
   localparam int READOUT_AW       = 10;

   // Each internal state lasts this many clocks; five states form one machine cycle.
   localparam int CLKS_PER_STATE   = 3;
   localparam int STATES_PER_CYCLE = 5;

   // Addresses at or above this value lie outside the internal ROM.
   localparam logic [PC_W-1:0] INT_ROM_DEPTH = 12'h800;

   // Expander operation codes, first nibble bits 3:2.
   localparam logic [1:0] EXP_OP_READ  = 2'h0;
   localparam logic [1:0] EXP_OP_WRITE = 2'h1;
   localparam logic [1:0] EXP_OP_OR    = 2'h2;
   localparam logic [1:0] EXP_OP_AND   = 2'h3;

   // Expander ports are numbered four to seven.
   localparam logic [2:0] EXP_PORT_FIRST = 3'h4;
   localparam logic [2:0] EXP_PORT_LAST  = 3'h7;

   // Values after reset.
   localparam logic [DATA_W-1:0] BUS_RESET = 8'h00;
   localparam logic [NIB_W-1:0]  NIB_RESET = 4'h0;

   typedef enum logic [2:0] {st_addr, st_hold, st_strobe_a, st_strobe_b, st_finish} mebi_state_type;
   typedef enum logic [2:0] {op_idle, op_fetch_int, op_fetch_ext, op_read, op_write, op_exp} mebi_op_type;

endpackage

// ### src/mebi_ram.sv
module mebi_ram
   import mebi_pkg::*;
#(
   parameter int AW = RAM_AW,
   parameter int DW = DATA_W
) (
   // Clock and reset.
   input  wire logic          clk_sys_i,
   input  wire logic          reset_i,
   // Access port.
   input  wire logic          wr_en_i,
   input  wire logic          rd_en_i,
   input  wire logic [AW-1:0] addr_i,
   input  wire logic [DW-1:0] wdata_i,
   output logic      [DW-1:0] rdata_o
);

   logic [DW-1:0] mem [2**AW];

   // The array has no reset so its contents survive a reset.
   always_ff @(posedge clk_sys_i) begin
      if (wr_en_i) begin
         mem[addr_i] <= wdata_i;
      end
   end

   // Read data come from a register.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         rdata_o <= '0;
      end else if (rd_en_i) begin
         rdata_o <= mem[addr_i];
      end
   end

endmodule // mebi_ram

// ### src/mebi_top.sv
module mebi_top
   import mebi_pkg::*;
(
   // Clock and reset.
   input  wire logic              clk_sys_i,
   input  wire logic              reset_i,
   // Core requests, sampled as a machine cycle begins; the clock-output enable is taken on any clock.
   input  wire logic              fetch_req_i,
   input  wire logic [PC_W-1:0]   fetch_pc_i,
   input  wire logic              data_rd_req_i,
   input  wire logic              data_wr_req_i,
   input  wire logic [DATA_W-1:0] pointer_registers_i,
   input  wire logic [DATA_W-1:0] data_wdata_i,
   input  wire logic              exp_req_i,
   input  wire logic [1:0]        exp_code_i,
   input  wire logic [2:0]        exp_port_i,
   input  wire logic [NIB_W-1:0]  exp_wdata_i,
   input  wire logic              clock_output_enable_op_i,
   input  wire logic              mixed_mode_i,
   // Core answers.
   output logic                   cycle_start_o,
   output logic                   op_done_o,
   output logic                   instr_valid_o,
   output logic      [DATA_W-1:0] instr_o,
   output logic      [DATA_W-1:0] rd_data_o,
   output logic      [NIB_W-1:0]  exp_rdata_o,
   // Data RAM port of the core.
   input  wire logic [RAM_AW-1:0] ram_addr_i,
   input  wire logic              ram_wr_i,
   input  wire logic              ram_rd_i,
   input  wire logic [DATA_W-1:0] ram_wdata_i,
   output logic      [DATA_W-1:0] ram_rdata_o,
   // Internal program ROM.
   output logic      [ROM_AW-1:0] rom_addr_o,
   input  wire logic [DATA_W-1:0] rom_data_i,
   // Mode and control pins.
   input  wire logic              reset_pin_n_i,
   input  wire logic              external_access_select_i,
   input  wire logic              external_access_select_hv_i,
   input  wire logic              single_step_run_i,
   // Strobe pins.
   output logic                   address_latch_o,
   output logic                   program_fetch_strobe_n_o,
   output logic                   read_strobe_n_o,
   output logic                   write_strobe_n_o,
   output logic                   expander_strobe_o,
   // Data bus lines.
   input  wire logic [DATA_W-1:0] data_bus_lines_i,
   output logic      [DATA_W-1:0] data_bus_lines_o,
   output logic                   data_bus_lines_oe_n_o,
   // Port 2 low nibble.
   input  wire logic [NIB_W-1:0]  port2_low_nibble_i,
   output logic      [NIB_W-1:0]  port2_low_nibble_o,
   output logic                   port2_low_nibble_oe_n_o,
   // Test0 pin.
   output logic                   test0_pin_o,
   output logic                   test0_pin_oe_n_o
);

   mebi_state_type            state;
   mebi_op_type               op;
   mebi_op_type               next_op;
   logic                      tick;
   logic                      ph2;
   logic                      stall;
   logic                      cyc_edge;
   logic                      cap_edge;
   logic                      readout;
   logic                      reset_pin_q;
   logic                      clk_out_en;
   logic [PC_W-1:0]           addr_q;
   logic [DATA_W-1:0]         wdata_q;
   logic [1:0]                exp_code_q;
   logic [2:0]                exp_port_q;
   logic [NIB_W-1:0]          exp_wdata_q;
   logic [READOUT_AW-1:0]     ro_addr;
   logic [DATA_W-1:0]         ro_data;
   logic                      ram_wr_gated;
   logic                      ram_rd_gated;
   logic                      next_ale;
   logic                      next_program_fetch_strobe_n_n;
   logic                      next_rd_n;
   logic                      next_wr_n;
   logic                      next_exp_strobe;
   logic [DATA_W-1:0]         next_bus;
   logic                      next_bus_oe_n;
   logic [NIB_W-1:0]          next_p2;
   logic                      next_p2_oe_n;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);

   // Read-out owns the pins while the select pin sits at the programming level.
   assign readout  = external_access_select_hv_i;
   // A step-mode stop holds the cycle in its first state with the latch strobe high.
   assign stall    = readout || (state == st_addr && !single_step_run_i);
   assign cyc_edge = tick && state == st_finish;
   assign cap_edge = tick && state == st_strobe_b;

   mebi_phase #(
      .CLKS (CLKS_PER_STATE)
   ) u_phase (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .stall_i   (stall),
      .state_o   (state),
      .tick_o    (tick),
      .ph2_o     (ph2)
   );

   // The core is cut off from the RAM while the reset pin is low.
   assign ram_wr_gated = ram_wr_i && reset_pin_n_i;
   assign ram_rd_gated = ram_rd_i && reset_pin_n_i;

   mebi_ram #(
      .AW (RAM_AW),
      .DW (DATA_W)
   ) u_ram (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .wr_en_i   (ram_wr_gated),
      .rd_en_i   (ram_rd_gated),
      .addr_i    (ram_addr_i),
      .wdata_i   (ram_wdata_i),
      .rdata_o   (ram_rdata_o)
   );

   // Choose this cycle's bus operation; a data access wins over a fetch.
   always_comb begin
      next_op = op_idle;
      if (!reset_pin_n_i || readout) begin
         next_op = op_idle;
      end else if (data_rd_req_i) begin
         next_op = op_read;
      end else if (data_wr_req_i) begin
         next_op = op_write;
      end else if (exp_req_i && exp_port_i >= EXP_PORT_FIRST && exp_port_i <= EXP_PORT_LAST) begin
         next_op = op_exp;
      end else if (fetch_req_i) begin
         // External-only fetches from address zero; mixed only above the ROM.
         if (external_access_select_i || (mixed_mode_i && fetch_pc_i >= INT_ROM_DEPTH)) begin
            next_op = op_fetch_ext;
         end else begin
            next_op = op_fetch_int;
         end
      end
   end

   // Requests are latched once per machine cycle so they stay stable across its states.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         op          <= op_idle;
         addr_q      <= '0;
         wdata_q     <= BUS_RESET;
         exp_code_q  <= EXP_OP_READ;
         exp_port_q  <= EXP_PORT_FIRST;
         exp_wdata_q <= NIB_RESET;
      end else if (cyc_edge) begin
         op          <= next_op;
         // Data accesses address through the selected pointer register.
         addr_q      <= (next_op == op_read || next_op == op_write) ? {4'h0, pointer_registers_i} : fetch_pc_i;
         wdata_q     <= data_wdata_i;
         exp_code_q  <= exp_code_i;
         exp_port_q  <= exp_port_i;
         exp_wdata_q <= exp_wdata_i;
      end
   end

   // Pin levels for the current state; they are registered below.
   always_comb begin
      next_ale        = state == st_addr && !readout;
      next_program_fetch_strobe_n_n     = 1'b1;
      next_rd_n       = 1'b1;
      next_wr_n       = 1'b1;
      next_exp_strobe = 1'b1;
      next_bus        = BUS_RESET;
      next_bus_oe_n   = 1'b1;
      next_p2         = NIB_RESET;
      next_p2_oe_n    = 1'b1;
      if (readout) begin
         if (reset_pin_n_i) begin
            next_bus      = ro_data;
            next_bus_oe_n = 1'b0;
         end
      end else begin
         case (state)
            st_addr, st_hold: begin
               if (op == op_fetch_ext || op == op_read || op == op_write) begin
                  next_bus      = addr_q[DATA_W-1:0];
                  next_bus_oe_n = 1'b0;
               end
               if (op == op_fetch_ext) begin
                  next_p2      = addr_q[PC_W-1:DATA_W];
                  next_p2_oe_n = 1'b0;
               end
               if (op == op_exp) begin
                  next_p2      = {exp_code_q, exp_port_q[1:0]};
                  next_p2_oe_n = 1'b0;
               end
            end
            st_strobe_a, st_strobe_b: begin
               // Only one strobe kind per cycle, the op decides which.
               next_program_fetch_strobe_n_n     = op != op_fetch_ext;
               next_rd_n       = op != op_read;
               next_wr_n       = op != op_write;
               next_exp_strobe = op != op_exp;
               if (op == op_write) begin
                  next_bus      = wdata_q;
                  next_bus_oe_n = 1'b0;
               end
               if (op == op_exp && exp_code_q != EXP_OP_READ) begin
                  next_p2      = exp_wdata_q;
                  next_p2_oe_n = 1'b0;
               end
            end
            st_finish: begin
               // Write data stay on the bus one state past the strobe's rising edge.
               if (op == op_write) begin
                  next_bus      = wdata_q;
                  next_bus_oe_n = 1'b0;
               end
            end
            default: begin
               next_bus_oe_n = 1'b1;
            end
         endcase
      end
   end

   // All pin outputs come from flip-flops.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         address_latch_o          <= 1'b0;
         program_fetch_strobe_n_o <= 1'b1;
         read_strobe_n_o          <= 1'b1;
         write_strobe_n_o         <= 1'b1;
         expander_strobe_o        <= 1'b1;
         data_bus_lines_o         <= BUS_RESET;
         data_bus_lines_oe_n_o    <= 1'b1;
         port2_low_nibble_o       <= NIB_RESET;
         port2_low_nibble_oe_n_o  <= 1'b1;
      end else begin
         address_latch_o          <= next_ale;
         program_fetch_strobe_n_o <= next_program_fetch_strobe_n_n;
         read_strobe_n_o          <= next_rd_n;
         write_strobe_n_o         <= next_wr_n;
         expander_strobe_o        <= next_exp_strobe;
         data_bus_lines_o         <= next_bus;
         data_bus_lines_oe_n_o    <= next_bus_oe_n;
         port2_low_nibble_o       <= next_p2;
         port2_low_nibble_oe_n_o  <= next_p2_oe_n;
      end
   end

   // Captures happen on the last clock before the strobe pins rise, where outside data must be valid.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         op_done_o     <= 1'b0;
         instr_valid_o <= 1'b0;
         cycle_start_o <= 1'b0;
         instr_o       <= BUS_RESET;
         rd_data_o     <= BUS_RESET;
         exp_rdata_o   <= NIB_RESET;
      end else begin
         op_done_o     <= cap_edge && op != op_idle;
         instr_valid_o <= cap_edge && (op == op_fetch_ext || op == op_fetch_int);
         cycle_start_o <= cyc_edge;
         if (cap_edge && op == op_fetch_ext) begin
            instr_o <= data_bus_lines_i;
         end else if (cap_edge && op == op_fetch_int) begin
            instr_o <= rom_data_i;
         end
         if (cap_edge && op == op_read) begin
            rd_data_o <= data_bus_lines_i;
         end
         if (cap_edge && op == op_exp && exp_code_q == EXP_OP_READ) begin
            exp_rdata_o <= port2_low_nibble_i;
         end
      end
   end

   // Read-out address is taken on the reset pin's rising edge.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         reset_pin_q <= 1'b0;
         ro_addr     <= '0;
         ro_data     <= BUS_RESET;
      end else begin
         reset_pin_q <= reset_pin_n_i;
         ro_data     <= rom_data_i;
         if (readout && reset_pin_n_i && !reset_pin_q) begin
            ro_addr <= {port2_low_nibble_i[1:0], data_bus_lines_i};
         end
      end
   end

   // In read-out the ROM follows the latched address, otherwise the cycle's address (the PC, or the pointer for data accesses).
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         rom_addr_o <= '0;
      end else if (readout) begin
         rom_addr_o <= ROM_AW'(ro_addr);
      end else begin
         rom_addr_o <= addr_q[ROM_AW-1:0];
      end
   end

   // Clock output stays off until enabled; a pin reset turns it off again.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || !reset_pin_n_i) begin
         clk_out_en <= 1'b0;
      end else if (clock_output_enable_op_i) begin
         clk_out_en <= 1'b1;
      end
   end

   // Test0 carries the phase-two clock once enabled.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         test0_pin_o      <= 1'b0;
         test0_pin_oe_n_o <= 1'b1;
      end else begin
         test0_pin_o      <= ph2 && clk_out_en;
         test0_pin_oe_n_o <= !clk_out_en;
      end
   end

   sequence s_fetch_addr;
      $fell(address_latch_o) && op == op_fetch_ext;
   endsequence

   sequence s_exp_first;
      $fell(expander_strobe_o);
   endsequence

   a_ale_low_span: assert property (disable iff (reset_i || readout)
      $fell(address_latch_o) |-> !address_latch_o [*8])
      else $error("Latch strobe high again too soon.");

   a_fetch_after_ale: assert property (s_fetch_addr |-> ##[1:8] !program_fetch_strobe_n_o)
      else $error("Fetch strobe did not follow the latch strobe.");

   a_program_fetch_strobe_n_ext_only: assert property (!program_fetch_strobe_n_o |-> op == op_fetch_ext)
      else $error("Fetch strobe low outside an external fetch.");

   a_strobe_exclusive: assert property (
      !(!program_fetch_strobe_n_o && (!read_strobe_n_o || !write_strobe_n_o)))
      else $error("Fetch strobe overlaps a data strobe.");

   a_write_data_hold: assert property ($rose(write_strobe_n_o)
      |-> !data_bus_lines_oe_n_o && $stable(data_bus_lines_o))
      else $error("Write data dropped at write strobe end.");

   a_bus_floats: assert property (op == op_idle && !readout && $past(op) == op_idle |-> data_bus_lines_oe_n_o)
      else $error("Bus driven with no access.");

   a_exp_nibble_one: assert property (s_exp_first
      |-> $past(port2_low_nibble_o) == {exp_code_q, exp_port_q[1:0]})
      else $error("First expander nibble wrong.");

   a_clk_out_on: assert property (clock_output_enable_op_i && reset_pin_n_i ##1 reset_pin_n_i
      |-> ##1 !test0_pin_oe_n_o)
      else $error("Clock output not enabled.");

   // A read while the reset pin is low must leave the read register untouched.
   a_ram_blocked: assert property (!reset_pin_n_i && ram_rd_i |=> $stable(ram_rdata_o))
      else $error("RAM reached while reset pin low.");

   a_readout_latch: assert property (readout && $rose(reset_pin_n_i)
      |=> ro_addr == {2'($past(port2_low_nibble_i)), $past(data_bus_lines_i)})
      else $error("Read-out address not latched.");

   a_step_hold: assert property (!readout && state == st_addr && !single_step_run_i
      ##1 state == st_addr |-> address_latch_o)
      else $error("Latch strobe low while stopped.");

endmodule // mebi_top
